// *** rtl/mre_pkg.sv ***
// shared constants for the move/rotate execution unit
package mre_pkg;
    localparam int unsigned WORD_W      = 14;           // instruction word width
    localparam int unsigned DATA_W      = 8;            // data path width
    localparam int unsigned ADDR_W      = 7;            // file address width
    localparam int unsigned FILE_DEPTH  = 128;          // file registers 0..127
    localparam int unsigned DEST_BIT    = 7;            // destination select position
    localparam int unsigned CARRY_BIT   = 0;            // carry position in status
    // opcode patterns
    localparam logic [5:0]  OPC_ROT_L   = 6'h0D;        // 00 1101 d fffffff
    localparam logic [6:0]  OPC_COPY    = 7'h01;        // 00 0000 1 fffffff
    localparam logic [3:0]  OPC_LIT     = 4'hC;         // 11 00xx kkkkkkkk
    localparam logic [13:0] OPC_NOP     = 14'h0000;     // 00 0000 0xx0 0000
    localparam logic [13:0] NOP_MASK    = 14'h3F9F;     // don't-care bits cleared
    // reset values and the timer zero count address
    localparam logic [7:0]  ACC_RST     = 8'h00;
    localparam logic [7:0]  STATUS_RST  = 8'h00;
    localparam logic [6:0]  TZ_CNT_ADDR = 7'h01;        // timer zero count address
    // decoded operation
    typedef enum logic [2:0] {
        MRE_OP_NONE   = 3'b000,
        MRE_OP_COPY   = 3'b001,
        MRE_OP_LIT    = 3'b010,
        MRE_OP_NOP    = 3'b011,
        MRE_OP_ROT_L  = 3'b100
    } mre_op_e;
endpackage

// *** rtl/mre_file_if.sv ***
`timescale 1ns/10ps
// file register port between core and its memory
interface mre_file_if;
    logic [6:0] rd_addr;    // read address
    logic [7:0] rd_data;    // registered read data
    logic       wr_en;      // write strobe
    logic [6:0] wr_addr;    // write address
    logic [7:0] wr_data;    // write data
    modport core (output rd_addr, wr_en, wr_addr, wr_data, input rd_data);
    modport mem  (input rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface

// *** rtl/mre_file_mem.sv ***
`timescale 1ns/10ps
// file register memory, registered read
module mre_file_mem #(
    parameter int unsigned DEPTH = mre_pkg::FILE_DEPTH
) (
    input  wire logic clk_i,
    mre_file_if.mem   fif
);
    logic [7:0] mem_q [DEPTH];   // storage
    logic [7:0] rd_reg;          // read data register

    // write then registered read
    always_ff @(posedge clk_i) begin
        if (fif.wr_en) begin
            mem_q[fif.wr_addr] <= fif.wr_data;
        end
        rd_reg <= mem_q[fif.rd_addr];
    end
    assign fif.rd_data = rd_reg;
endmodule

// *** rtl/mre_exec.sv ***
`timescale 1ns/10ps
// two-phase execution: an instruction is taken in EXEC; ops needing the
// file value (rotate) wait one cycle in MRE_ST_OPND for registered read data.
module mre_exec (
    input  wire logic        clk_i,        // core clock
    input  wire logic        rst_i,        // async reset, high
    input  wire logic        instr_vld_i,  // instruction word valid
    input  wire logic [13:0] instr_i,      // instruction word
    output logic             instr_rdy_o,  // ready to take a word
    input  wire logic [6:0]  port_addr_i,  // address of the i/o port register
    input  wire logic [7:0]  port_pins_i,  // pin levels (asynchronous)
    input  wire logic        presc_tz_i,   // prescaler assigned to timer zero
    output logic             presc_clr_o,  // one-cycle prescaler clear
    output logic [7:0]       acc_o,        // accumulator
    output logic [7:0]       status_o,     // status register
    output logic             done_o        // one-cycle completion pulse
);
    typedef enum logic [1:0] {
        MRE_ST_EXEC = 2'b00,
        MRE_ST_OPND = 2'b01
    } mre_state_e;

    mre_file_if              fif ();        // file memory port
    mre_state_e              state_reg;     // sequencer state
    mre_state_e              state_next;
    logic [7:0]              acc_reg;       // accumulator
    logic [7:0]              acc_next;
    logic [7:0]              status_reg;    // status, carry in bit 0
    logic [7:0]              status_next;
    logic [6:0]              addr_reg;      // held file address
    logic                    dest_reg;      // held destination select
    logic                    presc_reg;     // prescaler clear pulse
    logic                    presc_next;
    logic                    done_reg;      // completion pulse
    logic                    done_next;
    logic [7:0]              pin_s1;        // pin sync stage 1
    logic [7:0]              pin_s2;        // pin sync stage 2
    mre_pkg::mre_op_e        op_dec;        // decoded op
    logic                    take;          // instruction accepted
    logic [7:0]              opnd;          // operand after port select
    logic [7:0]              rot_res;       // rotated value
    logic                    rot_cy;        // carry out of rotate
    logic                    wr_copy;       // copy writes file
    logic                    wr_rot;        // rotate writes file
    logic [6:0]              wr_addr;       // file write address

    // decode: literal uses only top nibble, don't-cares ignored
    assign op_dec =
        (instr_i[13:8] == mre_pkg::OPC_ROT_L)            ? mre_pkg::MRE_OP_ROT_L :
        (instr_i[13:7] == mre_pkg::OPC_COPY)             ? mre_pkg::MRE_OP_COPY  :
        (instr_i[13:10] == mre_pkg::OPC_LIT)             ? mre_pkg::MRE_OP_LIT   :
        ((instr_i & mre_pkg::NOP_MASK) == mre_pkg::OPC_NOP) ? mre_pkg::MRE_OP_NOP :
                                                           mre_pkg::MRE_OP_NONE;

    assign instr_rdy_o = (state_reg == MRE_ST_EXEC);
    assign take        = instr_vld_i && instr_rdy_o;

    // operand: pins replace the latch for the port register
    assign opnd    = (addr_reg == port_addr_i) ? pin_s2 : fif.rd_data;
    assign rot_res = {opnd[6:0], status_reg[mre_pkg::CARRY_BIT]};
    assign rot_cy  = opnd[7];

    // file port wiring
    assign wr_copy     = take && (op_dec == mre_pkg::MRE_OP_COPY);
    assign wr_rot      = (state_reg == MRE_ST_OPND) && dest_reg;
    assign wr_addr     = wr_copy ? instr_i[6:0] : addr_reg;
    assign fif.rd_addr = instr_i[6:0];
    assign fif.wr_en   = wr_copy || wr_rot;
    assign fif.wr_addr = wr_addr;
    assign fif.wr_data = wr_copy ? acc_reg : rot_res;

    // next-state and datapath
    always_comb begin
        state_next  = state_reg;
        acc_next    = acc_reg;
        status_next = status_reg;
        done_next   = 1'b0;
        presc_next  = fif.wr_en && (wr_addr == mre_pkg::TZ_CNT_ADDR) && presc_tz_i;
        case (state_reg)
            MRE_ST_EXEC: begin
                if (take) begin
                    case (op_dec)
                        mre_pkg::MRE_OP_COPY: begin
                            done_next = 1'b1;
                        end
                        mre_pkg::MRE_OP_LIT: begin
                            acc_next  = instr_i[7:0];
                            done_next = 1'b1;
                        end
                        mre_pkg::MRE_OP_ROT_L: begin
                            state_next = MRE_ST_OPND;                 // wait for read data
                        end
                        default: begin
                            done_next = 1'b1;
                        end
                    endcase
                end
            end
            MRE_ST_OPND: begin
                status_next[mre_pkg::CARRY_BIT] = rot_cy;
                if (!dest_reg) begin
                    acc_next = rot_res;
                end
                done_next  = 1'b1;
                state_next = MRE_ST_EXEC;
            end
            default: begin
                state_next = MRE_ST_EXEC;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg  <= MRE_ST_EXEC;
            acc_reg    <= mre_pkg::ACC_RST;
            status_reg <= mre_pkg::STATUS_RST;
            presc_reg  <= 1'b0;
            done_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            acc_reg    <= acc_next;
            status_reg <= status_next;
            presc_reg  <= presc_next;
            done_reg   <= done_next;
        end
    end

    // operand hold and pin synchroniser
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_reg <= 7'h00;
            dest_reg <= 1'b0;
            pin_s1   <= 8'h00;
            pin_s2   <= 8'h00;
        end else begin
            if (take) begin
                addr_reg <= instr_i[6:0];
                dest_reg <= instr_i[mre_pkg::DEST_BIT];
            end
            pin_s1 <= port_pins_i;
            pin_s2 <= pin_s1;
        end
    end

    mre_file_mem u_mem (
        .clk_i (clk_i),
        .fif   (fif)
    );

    assign acc_o       = acc_reg;
    assign status_o    = status_reg;
    assign presc_clr_o = presc_reg;
    assign done_o      = done_reg;

    // rotate sequence: the cycle in which a rotate is taken
    sequence s_rot_take;
        take && (op_dec == mre_pkg::MRE_OP_ROT_L);
    endsequence

    // rotate operand cycle, split by destination
    sequence s_rot_to_acc;
        (state_reg == MRE_ST_OPND) && !dest_reg;
    endsequence
    sequence s_rot_to_file;
        (state_reg == MRE_ST_OPND) && dest_reg;
    endsequence

    a_copy_flags_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_copy |=> $stable(status_reg))
        else $error("copy changed status");
    a_copy_writes_acc: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_copy |-> fif.wr_data == acc_reg)
        else $error("copy data not accumulator");
    a_lit_loads_acc: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && op_dec == mre_pkg::MRE_OP_LIT) |=>
            (acc_reg == $past(instr_i[7:0])) && $stable(status_reg))
        else $error("literal load wrong");
    a_rot_carry_out: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rot_take ##1 1'b1 |=> status_reg[0] == $past(opnd[7]))
        else $error("rotate carry wrong");
    a_rot_to_acc: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == MRE_ST_OPND && !dest_reg) |-> !fif.wr_en ##1 acc_reg == $past(rot_res))
        else $error("rotate to accumulator wrong");
    a_rot_to_file: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == MRE_ST_OPND && dest_reg) |-> fif.wr_en ##1 $stable(acc_reg))
        else $error("rotate to file wrong");
    a_rot_two_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rot_take |=> (state_reg == MRE_ST_OPND) ##1 done_reg)
        else $error("rotate sequence wrong");
    a_presc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (fif.wr_en && wr_addr == mre_pkg::TZ_CNT_ADDR && presc_tz_i) |=> presc_clr_o)
        else $error("prescaler not cleared");
    a_nop_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && op_dec == mre_pkg::MRE_OP_NOP) |-> !fif.wr_en ##1
            (done_reg && $stable(acc_reg) && $stable(status_reg)))
        else $error("no-op changed state");

    // bit order and flag scope of the rotate, file side of both writers
    a_rot_bit_order: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rot_to_acc |=>
            acc_reg == {$past(opnd[6:0]), $past(status_reg[mre_pkg::CARRY_BIT])})
        else $error("rotate bit order wrong");
    a_rot_other_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_reg == MRE_ST_OPND) |=> (status_reg[7:1] == $past(status_reg[7:1])))
        else $error("rotate changed other flags");
    a_rot_file_data: assert property (@(posedge clk_i) disable iff (rst_i)
        s_rot_to_file |-> (fif.wr_addr == addr_reg) && (fif.wr_data == rot_res))
        else $error("rotate file write wrong");
    a_copy_file_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_copy |-> fif.wr_addr == instr_i[6:0])
        else $error("copy address wrong");
endmodule

// *** tb/test_move_rotate_exec_unit.sv ***
`timescale 1ns/10ps
// self-checking bench for the move/rotate execution unit, driven at the falling edge
module test_move_rotate_exec_unit;
    logic        clk_i;        // 40 MHz core clock
    logic        rst_i;        // async reset, high
    logic        instr_vld_i;  // instruction valid
    logic [13:0] instr_i;      // instruction word
    logic        instr_rdy_o;  // ready from the unit
    logic [6:0]  port_addr_i;  // address treated as the i/o port
    logic [7:0]  port_pins_i;  // pin levels
    logic        presc_tz_i;   // prescaler assigned to timer zero
    logic        presc_clr_o;  // prescaler clear pulse
    logic [7:0]  acc_o;        // accumulator
    logic [7:0]  status_o;     // status, carry at bit 0
    logic        done_o;       // completion pulse
    int          error_cnt;    // mismatches
    int          cmp_count;    // comparisons made
    int          cyc_cnt = 0;  // cycles since start, for the hang limit
    logic        seen_clr;     // prescaler clear seen with the last completion

    mre_exec dut_u (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .instr_vld_i (instr_vld_i),
        .instr_i     (instr_i),
        .instr_rdy_o (instr_rdy_o),
        .port_addr_i (port_addr_i),
        .port_pins_i (port_pins_i),
        .presc_tz_i  (presc_tz_i),
        .presc_clr_o (presc_clr_o),
        .acc_o       (acc_o),
        .status_o    (status_o),
        .done_o      (done_o)
    );

    // clock generator, 25 ns period
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // compare one value and count it
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // print the counts and the verdict, then stop
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // issue one word at a falling edge, wait for completion and check its latency
    task automatic run_op(input logic [13:0] word, input int lat);
        int n;
        n = 0;
        while (instr_rdy_o !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        instr_i = word;
        instr_vld_i = 1'b1;
        @(posedge clk_i);
        n = 1;                                   // the taking edge is the first cycle
        @(negedge clk_i);
        instr_vld_i = 1'b0;
        check("rdy after take", {15'h0000, instr_rdy_o}, {15'h0000, lat == 1});
        while (done_o !== 1'b1 && n < 6) begin
            @(posedge clk_i);
            @(negedge clk_i);
            n++;
        end
        seen_clr = presc_clr_o;
        check("latency", 16'(n), 16'(lat));
        // one idle cycle: both pulses must have ended
        @(negedge clk_i);
        check("done pulse end", {15'h0000, done_o}, 16'h0000);
        check("clear pulse end", {15'h0000, presc_clr_o}, 16'h0000);
    endtask

    // literal load with don't-care bits set, flags untouched
    task automatic t_literal();
        run_op({4'hC, 2'b11, 8'hE6}, 1);
        check("acc literal", {8'h00, acc_o}, 16'h00E6);
        check("status literal", {8'h00, status_o}, 16'h0000);
    endtask

    // copy to the top address, then read it back through a rotate into acc
    task automatic t_copy_rot_acc();
        run_op({7'h01, 7'h7F}, 1);
        check("status copy", {8'h00, status_o}, 16'h0000);
        run_op({4'hC, 2'b00, 8'h00}, 1);
        run_op({6'h0D, 1'b0, 7'h7F}, 2);
        check("acc rotate d0", {8'h00, acc_o}, 16'h00CC);
        check("carry rotate d0", {8'h00, status_o}, 16'h0001);
    endtask

    // rotate back into the file, then observe the file through a second rotate
    task automatic t_rot_file();
        run_op({6'h0D, 1'b1, 7'h7F}, 2);
        check("acc kept d1", {8'h00, acc_o}, 16'h00CC);
        check("carry d1", {8'h00, status_o}, 16'h0001);
        run_op({6'h0D, 1'b0, 7'h7F}, 2);
        check("file after d1", {8'h00, acc_o}, 16'h009B);
    endtask

    // no-op with its don't-care bits set, and an unknown word, change nothing
    task automatic t_nop();
        run_op(14'h0060, 1);
        check("acc nop", {8'h00, acc_o}, 16'h009B);
        check("status nop", {8'h00, status_o}, 16'h0001);
        run_op(14'h3FFF, 1);
        check("acc unknown", {8'h00, acc_o}, 16'h009B);
        check("status unknown", {8'h00, status_o}, 16'h0001);
    endtask

    // rotate of the port address uses pin levels, not the written value
    task automatic t_port();
        run_op({7'h01, 7'h05}, 1);
        port_pins_i = 8'h81;
        repeat (4) @(negedge clk_i);
        run_op({6'h0D, 1'b0, 7'h05}, 2);
        check("acc port rotate", {8'h00, acc_o}, 16'h0003);
    endtask

    // timer zero writes clear the prescaler only when it is assigned
    task automatic t_timer();
        run_op({7'h01, 7'h01}, 1);
        check("clr unassigned", {15'h0000, seen_clr}, 16'h0000);
        presc_tz_i = 1'b1;
        run_op({7'h01, 7'h01}, 1);
        check("clr copy", {15'h0000, seen_clr}, 16'h0001);
        run_op({6'h0D, 1'b0, 7'h01}, 2);
        check("clr rotate d0", {15'h0000, seen_clr}, 16'h0000);
        run_op({6'h0D, 1'b1, 7'h01}, 2);
        check("clr rotate d1", {15'h0000, seen_clr}, 16'h0001);
    endtask

    // hang limit: a run far beyond the expected fifty or so cycles fails
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt >= 2000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // main sequence
    initial begin
        error_cnt = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        instr_vld_i = 1'b0;
        instr_i = 14'h0000;
        port_addr_i = 7'h05;
        port_pins_i = 8'h00;
        presc_tz_i = 1'b0;
        seen_clr = 1'b0;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        t_literal();
        t_copy_rot_acc();
        t_rot_file();
        t_nop();
        t_port();
        t_timer();
        give_verdict();
    end
endmodule
